/* rtl/ptd_decoder.sv */
// Transfer and miscellaneous field decoder with APB registers
//
// How it works
// - Format E decodes bits 43..39 into one strobe per defined misc code.
// - The no-op code does nothing and keeps all status flags.
// - Queue wait stalls until the comm queue flag is clear, then completes.
// - Local mode is bits 35..38, global 13..16, each in its own formats.
// - Modes with upper bits 00 give no addressing on that unit.
// - Modes 01xx access at the register, then write back with the offset.
// - Modes 10xx access at register plus or minus offset, no write back.
// - Modes 11xx access at the sum and write it back.
// - The index always comes from the same unit as the address register.
// - Local type bits are 21 and 31, global are 17 and 9.
// - Type pairs give zero load, sign load, store or unit arithmetic.
// - Size 00 byte, 01 halfword, 10 word, 11 reserved.
// - Field moves in format 3 allow byte and halfword only.
// - Relative mode 00 absolute, 10 data RAM base, 11 parameter base.
// - Formats 7..10 pick one of 16 conditions gating source, result, global.
// - Format D applies the condition only to the result write.
// - Code 0000 always passes; 1000..1111 test C, Z, V, N set or clear.
// - Codes 0100..0111 are signed compares from N xor V and Z.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
module ptd_decoder (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               resetn_in,
    // APB slave
    input  wire logic               psel_in,
    input  wire logic               penable_in,
    input  wire logic               pwrite_in,
    input  wire logic [7:0]         paddr_in,
    input  wire logic [31:0]        pwdata_in,
    input  wire logic [3:0]         pstrb_in,
    output logic [31:0]             prdata_out,
    output logic                    pready_out,
    output logic                    pslverr_out,
    // Instruction from issue stage
    input  wire logic               instr_valid_in,
    input  wire logic [63:0]        instr_in,
    input  wire logic [3:0]         pfmt_in,
    input  wire logic               fmt_e_in,
    input  wire logic               fmt_d_in,
    input  wire ptd_pkg::ptd_gate_t cond_sel_in,
    input  wire ptd_pkg::ptd_xfer_t lxfer_in,
    input  wire ptd_pkg::ptd_xfer_t gxfer_in,
    output logic                    instr_ready_out,
    // Status from data unit and queue
    input  wire ptd_pkg::ptd_flags_t flags_in,
    input  wire logic               commq_in,
    // Decoded controls
    output ptd_pkg::ptd_misc_t      misc_out,
    output logic                    flag_keep_out,
    output ptd_pkg::ptd_addr_t      laddr_out,
    output ptd_pkg::ptd_addr_t      gaddr_out,
    output logic                    cond_pass_out,
    output ptd_pkg::ptd_gate_t      gate_out,
    output logic                    stall_out,
    output logic                    done_out
);
    import ptd_pkg::*;

    typedef struct packed {
        ptd_fsm_t   fsm;
        logic       pready;
        logic       pslverr;
        logic [31:0] prdata;
        logic       ctrl_en;
        logic [31:0] stalls;
        logic [63:0] last;
        logic       ready;
        ptd_misc_t  misc;
        logic       flag_keep;
        ptd_addr_t  laddr;
        ptd_addr_t  gaddr;
        logic       cond_pass;
        ptd_gate_t  gate;
        logic       stall;
        logic       done;
    } ptd_state_t;

    ptd_state_t r;
    ptd_state_t next_r;

    // Condition evaluation from status flags
    function automatic logic cond_eval(input logic [3:0] cc, input ptd_flags_t f);
        logic p;
        p = 1'b0;
        case (cc)
            CC_U:    p = 1'b1;
            CC_P:    p = ~f.n & ~f.z;
            CC_LS:   p = ~f.c | f.z;
            CC_HI:   p = f.c & ~f.z;
            CC_LT:   p = f.n ^ f.v;
            CC_LE:   p = (f.n ^ f.v) | f.z;
            CC_GE:   p = ~(f.n ^ f.v);
            CC_GT:   p = ~(f.n ^ f.v) & ~f.z;
            CC_C:    p = f.c;
            CC_NC:   p = ~f.c;
            CC_Z:    p = f.z;
            CC_NZ:   p = ~f.z;
            CC_V:    p = f.v;
            CC_NV:   p = ~f.v;
            CC_N:    p = f.n;
            default: p = ~f.n;
        endcase
        return p;
    endfunction

    // Address-unit decode, used for the local and the global unit
    function automatic ptd_addr_t addr_dec(input logic [3:0] mode,
                                           input logic       lsel,
                                           input logic       esel,
                                           input ptd_xfer_t  x,
                                           input logic       field);
        ptd_addr_t a;
        logic      bad;
        a   = '0;
        bad = (x.size == SIZE_RSVD) || (x.rm == RM_RSVD);
        bad = bad || (field && x.size[1]);
        if (mode[MB_PRE:MB_WB] != 2'h0) begin
            a.err = bad;
            if (!bad) begin
                a.pre     = mode[MB_PRE];
                a.wb      = mode[MB_WB];
                a.sub     = mode[MB_SUB];
                a.use_imm = mode[MB_IMM];
                a.use_idx = ~mode[MB_IMM];
                a.width   = x.size;
                a.base    = x.rm;
                a.load    = lsel;
                a.sext    = lsel & esel;
                a.store   = ~lsel & ~esel;
                a.arith   = ~lsel & esel;
                a.mem     = ~(~lsel & esel);
            end
        end
        return a;
    endfunction

    // Misc code to strobes; reserved codes give none
    function automatic ptd_misc_t misc_dec(input logic [4:0] code);
        ptd_misc_t m;
        m = '0;
        case (code)
            MISC_NOP:   m.nop   = 1'b1;
            MISC_QWAIT: m.qwait = 1'b1;
            MISC_EINT:  m.eint  = 1'b1;
            MISC_DINT:  m.dint  = 1'b1;
            MISC_ELOOP: m.eloop = 1'b1;
            MISC_DLOOP: m.dloop = 1'b1;
            default:    m       = '0;
        endcase
        return m;
    endfunction

    logic       apb_access;
    logic       apb_take;
    logic       mapped;
    logic [31:0] rd_word;
    logic       accept;
    ptd_misc_t  dec_misc;
    logic       misc_idle;
    logic       lsel_used;
    logic       gsel_used;
    logic       csel_used;
    logic       cpass;

    always_comb begin
        next_r     = r;
        apb_access = psel_in & penable_in;
        apb_take   = apb_access & r.pready;
        mapped     = 1'b1;
        rd_word    = 32'h0000_0000;
        case (paddr_in)
            REG_CTRL:    rd_word = {31'h0000_0000, r.ctrl_en};
            REG_STATUS:  rd_word = {29'h0000_0000, r.cond_pass, r.stall, r.ready};
            REG_STALLS:  rd_word = r.stalls;
            REG_LAST_LO: rd_word = r.last[31:0];
            REG_LAST_HI: rd_word = r.last[63:32];
            default:     mapped  = 1'b0;
        endcase

        // APB: one wait state, then a one-cycle ready
        next_r.pready = 1'b0;
        if (apb_access && !r.pready) begin
            next_r.pready  = 1'b1;
            next_r.pslverr = ~mapped;
            next_r.prdata  = pwrite_in ? 32'h0000_0000 : rd_word;
        end

        // Decoder pulses last one cycle
        next_r.misc      = '0;
        next_r.flag_keep = 1'b0;
        next_r.laddr     = '0;
        next_r.gaddr     = '0;
        next_r.gate      = '0;
        next_r.done      = 1'b0;

        dec_misc  = misc_dec(instr_in[MISC_HI:MISC_LO]);
        misc_idle = 1'b1;
        if (fmt_e_in) begin
            misc_idle = dec_misc.nop || (dec_misc == '0);
        end
        lsel_used = LMODE_FMTS[pfmt_in];
        gsel_used = GMODE_FMTS[pfmt_in];
        csel_used = COND_FMTS[pfmt_in];
        cpass     = cond_eval(instr_in[COND_HI:COND_LO], flags_in);
        accept    = instr_valid_in & r.ready;

        case (r.fsm)
            ST_IDLE: begin
                if (accept) begin
                    next_r.last      = instr_in;
                    next_r.flag_keep = fmt_e_in & misc_idle;
                    if (lsel_used) begin
                        next_r.laddr = addr_dec(instr_in[LMODE_HI:LMODE_LO],
                                                instr_in[LSEL_L], instr_in[LSEL_E],
                                                lxfer_in, pfmt_in == FMT_FIELD);
                    end
                    if (gsel_used) begin
                        next_r.gaddr = addr_dec(instr_in[GMODE_HI:GMODE_LO],
                                                instr_in[GSEL_L], instr_in[GSEL_E],
                                                gxfer_in, 1'b0);
                    end
                    next_r.cond_pass = 1'b1;
                    if (fmt_d_in) begin
                        next_r.cond_pass = cpass;
                        next_r.gate.res  = 1'b1;
                    end else if (csel_used) begin
                        next_r.cond_pass = cpass;
                        next_r.gate      = cond_sel_in;
                    end
                    if (fmt_e_in && dec_misc.qwait && commq_in) begin
                        next_r.fsm   = ST_WAIT;
                        next_r.stall = 1'b1;
                        next_r.ready = 1'b0;
                    end else begin
                        next_r.misc = fmt_e_in ? dec_misc : '0;
                        next_r.done = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (!commq_in) begin
                    next_r.fsm        = ST_IDLE;
                    next_r.stall      = 1'b0;
                    next_r.misc.qwait = 1'b1;
                    next_r.done       = 1'b1;
                end else begin
                    next_r.stalls = r.stalls + 32'h0000_0001;
                end
            end
            default: begin
                next_r.fsm   = ST_IDLE;
                next_r.stall = 1'b0;
            end
        endcase

        // Register writes take effect at the completing edge
        if (apb_take && pwrite_in && !r.pslverr) begin
            if (paddr_in == REG_CTRL && pstrb_in[0]) begin
                next_r.ctrl_en = pwdata_in[0];
            end
            if (paddr_in == REG_STALLS) begin
                next_r.stalls = 32'h0000_0000;
            end
        end
        if (next_r.fsm == ST_IDLE) begin
            next_r.ready = next_r.ctrl_en;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r         <= '0;
            r.fsm     <= ST_IDLE;
            r.ctrl_en <= CTRL_EN_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign prdata_out      = r.prdata;
    assign pready_out      = r.pready;
    assign pslverr_out     = r.pslverr;
    assign instr_ready_out = r.ready;
    assign misc_out        = r.misc;
    assign flag_keep_out   = r.flag_keep;
    assign laddr_out       = r.laddr;
    assign gaddr_out       = r.gaddr;
    assign cond_pass_out   = r.cond_pass;
    assign gate_out        = r.gate;
    assign stall_out       = r.stall;
    assign done_out        = r.done;
endmodule

/* rtl/ptd_pkg.sv */
// Shared constants and types for the transfer field decoder
package ptd_pkg;
    // Register map and reset values
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_STALLS  = 8'h08;
    localparam logic [7:0]  REG_LAST_LO = 8'h0c;
    localparam logic [7:0]  REG_LAST_HI = 8'h10;
    localparam logic        CTRL_EN_RST = 1'b1;
    // Opcode field positions
    localparam int MISC_HI  = 43;
    localparam int MISC_LO  = 39;
    localparam int LMODE_HI = 38;
    localparam int LMODE_LO = 35;
    localparam int GMODE_HI = 16;
    localparam int GMODE_LO = 13;
    localparam int LSEL_L   = 21;
    localparam int LSEL_E   = 31;
    localparam int GSEL_L   = 17;
    localparam int GSEL_E   = 9;
    localparam int COND_HI  = 35;
    localparam int COND_LO  = 32;
    // Bits inside an addressing-mode code
    localparam int MB_SUB = 0;
    localparam int MB_IMM = 1;
    localparam int MB_WB  = 2;
    localparam int MB_PRE = 3;
    // Formats using each field, one bit per format number
    localparam logic [15:0] LMODE_FMTS = 16'h005e;
    localparam logic [15:0] GMODE_FMTS = 16'h0222;
    localparam logic [15:0] COND_FMTS  = 16'h0780;
    localparam logic [3:0]  FMT_FIELD  = 4'h3;
    // Miscellaneous operation codes
    localparam logic [4:0] MISC_NOP   = 5'h00;
    localparam logic [4:0] MISC_QWAIT = 5'h01;
    localparam logic [4:0] MISC_EINT  = 5'h02;
    localparam logic [4:0] MISC_DINT  = 5'h03;
    localparam logic [4:0] MISC_ELOOP = 5'h04;
    localparam logic [4:0] MISC_DLOOP = 5'h05;
    // Size and relative-mode codes
    localparam logic [1:0] SIZE_RSVD = 2'h3;
    localparam logic [1:0] RM_RSVD   = 2'h1;
    // Condition codes
    localparam logic [3:0] CC_U = 4'h0, CC_P = 4'h1, CC_LS = 4'h2, CC_HI = 4'h3;
    localparam logic [3:0] CC_LT = 4'h4, CC_LE = 4'h5, CC_GE = 4'h6, CC_GT = 4'h7;
    localparam logic [3:0] CC_C = 4'h8, CC_NC = 4'h9, CC_Z = 4'ha, CC_NZ = 4'hb;
    localparam logic [3:0] CC_V = 4'hc, CC_NV = 4'hd, CC_N = 4'he;

    typedef enum logic [0:0] {ST_IDLE, ST_WAIT} ptd_fsm_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } ptd_flags_t;

    typedef struct packed {
        logic [1:0] size;
        logic [1:0] rm;
    } ptd_xfer_t;

    typedef struct packed {
        logic src;
        logic res;
        logic glb;
    } ptd_gate_t;

    typedef struct packed {
        logic nop;
        logic qwait;
        logic eint;
        logic dint;
        logic eloop;
        logic dloop;
    } ptd_misc_t;

    typedef struct packed {
        logic       mem;
        logic       arith;
        logic       load;
        logic       sext;
        logic       store;
        logic       use_idx;
        logic       use_imm;
        logic       sub;
        logic       pre;
        logic       wb;
        logic [1:0] width;
        logic [1:0] base;
        logic       err;
    } ptd_addr_t;
endpackage

/* dv/ptd_checker.sv */
// Assertion checker for the transfer field decoder
`timescale 1ns/100ps
module ptd_checker (
    // Clock, reset and bus handshake
    input wire logic               clk_in,
    input wire logic               resetn_in,
    input wire logic               psel_in,
    input wire logic               penable_in,
    input wire logic               pready_out,
    // Instruction side
    input wire logic               instr_valid_in,
    input wire logic [63:0]        instr_in,
    input wire logic [3:0]         pfmt_in,
    input wire logic               fmt_e_in,
    input wire logic               fmt_d_in,
    input wire ptd_pkg::ptd_gate_t cond_sel_in,
    input wire ptd_pkg::ptd_xfer_t lxfer_in,
    input wire ptd_pkg::ptd_xfer_t gxfer_in,
    input wire logic               instr_ready_out,
    input wire logic               commq_in,
    // Decoded controls
    input wire ptd_pkg::ptd_misc_t misc_out,
    input wire logic               flag_keep_out,
    input wire ptd_pkg::ptd_addr_t laddr_out,
    input wire ptd_pkg::ptd_addr_t gaddr_out,
    input wire ptd_pkg::ptd_gate_t gate_out,
    input wire logic               stall_out,
    input wire logic               done_out
);
    import ptd_pkg::*;
    logic acc, lok, gok;
    assign acc = instr_valid_in & instr_ready_out;
    assign lok = acc & LMODE_FMTS[pfmt_in] & (pfmt_in != FMT_FIELD) & (instr_in[38:37] != 2'h0)
               & (lxfer_in.size != SIZE_RSVD) & (lxfer_in.rm != RM_RSVD);
    assign gok = acc & GMODE_FMTS[pfmt_in] & (instr_in[16:15] != 2'h0)
               & (gxfer_in.size != SIZE_RSVD) & (gxfer_in.rm != RM_RSVD);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_misc_rsvd;
        acc && fmt_e_in && instr_in[43:39] > MISC_DLOOP |=> misc_out == 6'h00 && flag_keep_out;
    endproperty
    a_misc_rsvd: assert property (p_misc_rsvd) else $error("reserved misc code acted");
    property p_qwait_hold;
        acc && fmt_e_in && instr_in[43:39] == MISC_QWAIT && commq_in
            |=> stall_out && !done_out && !instr_ready_out;
    endproperty
    a_qwait_hold: assert property (p_qwait_hold) else $error("queue wait did not stall");
    property p_qwait_end;
        stall_out && !commq_in |=> !stall_out && done_out && misc_out.qwait;
    endproperty
    a_qwait_end: assert property (p_qwait_end) else $error("queue wait did not finish");
    property p_nomode;
        acc && instr_in[38:37] == 2'h0 |=> laddr_out == 15'h0;
    endproperty
    a_nomode: assert property (p_nomode) else $error("local unit active on nop mode");
    property p_prewb;
        lok |=> {laddr_out.pre, laddr_out.wb} == $past(instr_in[38:37]);
    endproperty
    a_prewb: assert property (p_prewb) else $error("pre or write back wrong");
    property p_gidx;
        gok |=> gaddr_out.use_idx == !$past(instr_in[14]) && gaddr_out.sub == $past(instr_in[13]);
    endproperty
    a_gidx: assert property (p_gidx) else $error("global offset select wrong");
    property p_ltype;
        lok |=> laddr_out.load == $past(instr_in[21]) && laddr_out.sext == $past(instr_in[21] & instr_in[31]);
    endproperty
    a_ltype: assert property (p_ltype) else $error("local transfer type wrong");
    property p_lsize;
        acc && LMODE_FMTS[pfmt_in] && instr_in[38:37] != 2'h0 && lxfer_in.size == SIZE_RSVD
            |=> laddr_out.err && !laddr_out.mem;
    endproperty
    a_lsize: assert property (p_lsize) else $error("reserved size accepted");
    property p_gate;
        acc && COND_FMTS[pfmt_in] && !fmt_d_in |=> gate_out == $past(cond_sel_in);
    endproperty
    a_gate: assert property (p_gate) else $error("condition gates wrong");
    property p_apb;
        psel_in && penable_in && !pready_out |=> pready_out;
    endproperty
    a_apb: assert property (p_apb) else $error("bus access not answered");
endmodule

bind ptd_decoder ptd_checker ptd_checker_inst (.clk_in, .resetn_in, .psel_in, .penable_in, .pready_out,
    .instr_valid_in, .instr_in, .pfmt_in, .fmt_e_in, .cond_sel_in, .lxfer_in, .gxfer_in, .instr_ready_out,
    .commq_in, .fmt_d_in, .misc_out, .flag_keep_out, .laddr_out, .gaddr_out, .gate_out, .stall_out, .done_out);

/* dv/ptd_issue_model.sv */
// Issue stage model that offers instructions to the decoder
`timescale 1ns/100ps
module ptd_issue_model (
    // Clock and handshake
    input  wire logic          clk_in,
    input  wire logic          ready_in,
    output logic               valid_out,
    // Instruction and side fields
    output logic [63:0]        instr_out,
    output logic [3:0]         pfmt_out,
    output logic               fmt_e_out,
    output logic               fmt_d_out,
    output ptd_pkg::ptd_gate_t sel_out,
    output ptd_pkg::ptd_xfer_t lx_out,
    output ptd_pkg::ptd_xfer_t gx_out
);
    import ptd_pkg::*;
    initial begin
        {valid_out, instr_out, pfmt_out, fmt_e_out, fmt_d_out, sel_out, lx_out, gx_out} = 82'h0;
    end
    // Offer one word and hold it until the decoder takes it
    task automatic issue(input logic [63:0] w, input logic [3:0] f, input logic e, input logic d,
                         input ptd_gate_t s, input ptd_xfer_t lx, input ptd_xfer_t gx);
        @(posedge clk_in);
        {valid_out, instr_out, pfmt_out, fmt_e_out, fmt_d_out, sel_out, lx_out, gx_out} <=
            {1'b1, w, f, e, d, s, lx, gx};
        do @(posedge clk_in); while (ready_in !== 1'b1);
        valid_out <= 1'b0;
        instr_out <= ~w;
    endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the transfer field decoder
`timescale 1ns/100ps
module tb;
    import ptd_pkg::*;
    logic        clk_in = 1'b0, resetn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic        commq_in = 1'b0, pready_out, pslverr_out, instr_valid_in, fmt_e_in, fmt_d_in, er;
    logic        instr_ready_out, flag_keep_out, cond_pass_out, stall_out, done_out;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic [3:0]  pstrb_in = 4'hf, pfmt_in;
    logic [63:0] instr_in, w;
    logic [8:0]  cases [4] = '{9'h0d9, 9'h043, 9'h071, 9'h068};
    ptd_flags_t  flags_in = 4'h0;
    ptd_gate_t   cond_sel_in, gate_out;
    ptd_xfer_t   lxfer_in, gxfer_in;
    ptd_misc_t   misc_out;
    ptd_addr_t   laddr_out, gaddr_out, ea;
    int          bad_count = 0, cmp_count = 0;

    always #2.5 clk_in = ~clk_in;

    ptd_decoder ptd_decoder_inst (.clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .instr_valid_in, .instr_in, .pfmt_in, .fmt_e_in,
        .fmt_d_in, .cond_sel_in, .lxfer_in, .gxfer_in, .instr_ready_out, .flags_in, .commq_in, .misc_out,
        .flag_keep_out, .laddr_out, .gaddr_out, .cond_pass_out, .gate_out, .stall_out, .done_out);
    ptd_issue_model ptd_issue_model_inst (.clk_in, .ready_in(instr_ready_out), .valid_out(instr_valid_in),
        .instr_out(instr_in), .pfmt_out(pfmt_in), .fmt_e_out(fmt_e_in), .fmt_d_out(fmt_d_in),
        .sel_out(cond_sel_in), .lx_out(lxfer_in), .gx_out(gxfer_in));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
    endtask

    task automatic go(input logic [63:0] x, input logic [3:0] f, input logic e, input logic d,
                      input ptd_gate_t s, input ptd_xfer_t lx);
        ptd_issue_model_inst.issue(x, f, e, d, s, lx, 4'h8);
        @(negedge clk_in);
    endtask

    function automatic logic cc_exp(input logic [3:0] cc, input logic [3:0] f);
        logic n, z, c, v;
        logic [3:0] pick;
        {n, z, c, v} = f;
        pick = {n, v, z, c};
        case (cc)
            4'h0: return 1'b1;
            4'h1: return !n && !z;
            4'h2: return !c || z;
            4'h3: return c && !z;
            4'h4: return n ^ v;
            4'h5: return (n ^ v) || z;
            4'h6: return !(n ^ v);
            4'h7: return !(n ^ v) && !z;
            default: return cc[0] ^ pick[cc[2:1]];
        endcase
    endfunction

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        // Registers: reset value, unmapped access, enable gating
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (2) @(negedge clk_in);
        chk(instr_ready_out, 1'b0);
        apb(1'b1, REG_CTRL, 32'h1);
        // Every miscellaneous code
        for (int c = 0; c < 32; c++) begin
            go({20'h0, c[4:0], 39'h0}, 4'h0, 1'b1, 1'b0, 3'h0, 4'h0);
            chk(misc_out, c < 6 ? 6'h20 >> c : 6'h00);
            chk({flag_keep_out, done_out}, {c == 0 || c > 5, 1'b1});
        end
        // Queue wait held by a busy queue
        @(posedge clk_in);
        commq_in <= 1'b1;
        w = {20'h0, MISC_QWAIT, 39'h0} | 64'h1234_5678;
        go(w, 4'h0, 1'b1, 1'b0, 3'h0, 4'h0);
        repeat (3) @(negedge clk_in);
        chk({stall_out, done_out, instr_ready_out}, 3'b100);
        @(posedge clk_in);
        commq_in <= 1'b0;
        @(posedge clk_in);
        @(negedge clk_in);
        chk({stall_out, done_out, misc_out.qwait}, 3'b011);
        apb(1'b0, REG_LAST_LO, 32'h0);
        chk(rd, w[31:0]);
        apb(1'b0, REG_LAST_HI, 32'h0);
        chk(rd, w[63:32]);
        // Status after the wait, stall count and its clear
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, REG_STALLS, 32'h0);
        chk(rd, 32'h4);
        apb(1'b1, REG_STALLS, 32'h0);
        apb(1'b0, REG_STALLS, 32'h0);
        chk(rd, 32'h0);
        // All modes and types on both units
        for (int u = 0; u < 2; u++)
            for (int m = 0; m < 16; m++)
                for (int t = 0; t < 4; t++) begin
                    w = u ? {46'h0, t[1], m[3:0], 3'h0, t[0], 9'h0}
                          : {25'h0, m[3:0], 3'h0, t[0], 9'h0, t[1], 21'h0};
                    go(w, u ? 4'h5 : 4'h2, 1'b0, 1'b0, 3'h0, 4'h8);
                    ea = (m > 3) ? {t != 1, t == 1, t[1], t == 3, t == 0, !m[1], m[1], m[0], m[3], m[2], 5'h10}
                                 : 15'h0;
                    chk(u ? gaddr_out : laddr_out, ea);
                    chk(u ? laddr_out : gaddr_out, 15'h0);
                end
        // Reserved size, reserved relative mode, field move sizes
        for (int k = 0; k < 4; k++) begin
            go(64'h0000_0060_0000_0000, cases[k][8:5], 1'b0, 1'b0, 3'h0, cases[k][4:1]);
            chk({laddr_out.err, laddr_out.mem}, {cases[k][0], !cases[k][0]});
        end
        // Every condition against every flag pattern
        for (int cc = 0; cc < 16; cc++)
            for (int f = 0; f < 16; f++) begin
                @(posedge clk_in);
                flags_in <= f[3:0];
                go({28'h0, cc[3:0], 32'h0}, 4'h7, 1'b0, 1'b0, 3'h5, 4'h0);
                rd = {28'h0, cc_exp(cc[3:0], f[3:0]), 3'h5};
                chk({cond_pass_out, gate_out}, rd[3:0]);
            end
        go(64'h0, 4'h0, 1'b0, 1'b1, 3'h7, 4'h0);
        chk(gate_out, 3'h2);
        report_and_stop();
    end
endmodule
